// [rtl/vir_ctrl.v]
// Overview of operation
// - Ten request sources, each with its own vector entry.
// - Maskable priorities 7 highest to 1 lowest; highest served first.
// - Maskable request accepted only if priority exceeds threshold field.
// - Cleared global enable blocks every maskable request.
// - Sixteen vector entries live at 1000 through 101F.
// - External line a: vector 1000, priority 7.
// - External line b: priority 4; vector location a parameter.
// - Watchdog vectors to 1006, unfiltered by the mask.
// - Second and third timers vector to 100A, 100C, priority 3.
// - Conversion complete vectors to 1012, priority 2.
// - Servo block vectors to 1014, priority 5.
// - Undefined opcode vectors to 101E, unfiltered by the mask.
// - High reset pin holds logic in reset; start at 1020.
// - Reset clears the global interrupt enable.
// - Reset zeroes output latches, bidirectional pins to input.
// - Reset restores peripheral control registers to initial values.
`include "vir_map.vh"
`timescale 1ns/1ps
`default_nettype none
module vir_ctrl #(
    // Location not legible; confirm before tape-out
    parameter [15:0] EXT_B_VEC = 16'h1002
) (
    input wire i_clk, // 40 MHz system clock
    input wire i_nrst, // Async reset, active low
    input wire i_reset_pin, // External reset pin, active high
    input wire i_ext_irq_line_a, // External request a, async level
    input wire i_ext_irq_line_b, // External request b, async level
    input wire i_wdt_evt, // Watchdog event, one-cycle pulse
    input wire i_tmr_a_evt, // Interval timer a event pulse
    input wire i_tmr_b_evt, // Interval timer b event pulse
    input wire i_tmr_c_evt, // Interval timer c event pulse
    input wire i_ser_evt, // Serial transfer done pulse
    input wire i_adc_evt, // Conversion complete pulse
    input wire i_servo_evt, // Servo block event pulse
    input wire i_illegal_op, // Undefined opcode pulse
    input wire [2:0] i_threshold, // Priority threshold field
    input wire i_irq_enable_set, // Enable instruction pulse
    input wire i_irq_disable, // Disable instruction pulse
    input wire i_ack, // Core takes the offered vector
    input wire [7:0] i_port_out_wr, // Output latch write data
    input wire i_port_out_we, // Output latch write strobe
    input wire [7:0] i_port_dir_wr, // Direction write data
    input wire i_port_dir_we, // Direction write strobe
    input wire [7:0] i_ctl_wr, // Peripheral control write data
    input wire i_ctl_we, // Peripheral control write strobe
    output reg o_irq_req, // Request offered to core
    output reg [15:0] o_irq_vec, // Offered vector address
    output reg [2:0] o_irq_prio, // Priority of offered request
    output reg [9:0] o_pending, // Pending flags per source
    output reg o_irq_enable, // Global enable flag
    output reg o_core_rst, // Core held in reset
    output reg [15:0] o_start_addr, // Fetch address after reset
    output reg [7:0] o_port_out, // Output port latch
    output reg [7:0] o_port_oe, // Pin drive enable, 1 = output
    output reg [7:0] o_ctl // Peripheral control register
);
    localparam [3:0] S_EXTA = 4'h0;
    localparam [3:0] S_EXTB = 4'h1;
    localparam [3:0] S_WDT = 4'h2;
    localparam [3:0] S_TMRA = 4'h3;
    localparam [3:0] S_TMRB = 4'h4;
    localparam [3:0] S_TMRC = 4'h5;
    localparam [3:0] S_SER = 4'h6;
    localparam [3:0] S_ADC = 4'h7;
    localparam [3:0] S_SERVO = 4'h8;
    localparam [3:0] S_ILL = 4'h9;
    localparam [1:0] ST_IDLE = `VIR_ST_IDLE;
    localparam [1:0] ST_REQ = `VIR_ST_REQ;

    wire ext_a_s;
    wire ext_b_s;
    wire rst_pin_s;
    reg ext_a_d_reg;
    reg ext_b_d_reg;
    reg [1:0] st_reg;
    reg [3:0] sel_reg;
    reg [9:0] events;
    reg [9:0] pend_next;
    reg [9:0] take;
    reg found;
    reg [3:0] win;
    reg [2:0] win_prio;
    reg [2:0] cand_prio;
    reg unmasked;
    reg [15:0] win_vec;
    integer k;

    vir_sync2 u_sync_a (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_d(i_ext_irq_line_a),
        .o_q(ext_a_s)
    );
    vir_sync2 u_sync_b (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_d(i_ext_irq_line_b),
        .o_q(ext_b_s)
    );
    vir_sync2 u_sync_r (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_d(i_reset_pin),
        .o_q(rst_pin_s)
    );

    function [2:0] prio_of;
        input [3:0] s;
        begin
            case (s)
                S_EXTA: prio_of = `VIR_PRIO_EXT_A;
                S_EXTB: prio_of = `VIR_PRIO_EXT_B;
                S_TMRA: prio_of = `VIR_PRIO_TMR_A;
                S_TMRB: prio_of = `VIR_PRIO_TMR_B;
                S_TMRC: prio_of = `VIR_PRIO_TMR_C;
                S_SER: prio_of = `VIR_PRIO_SER;
                S_ADC: prio_of = `VIR_PRIO_ADC;
                S_SERVO: prio_of = `VIR_PRIO_SERVO;
                default: prio_of = `VIR_PRIO_NONE;
            endcase
        end
    endfunction

    function [15:0] vec_of;
        input [3:0] s;
        begin
            case (s)
                S_EXTA: vec_of = `VIR_VEC_EXT_A;
                S_EXTB: vec_of = EXT_B_VEC;
                S_WDT: vec_of = `VIR_VEC_WDT;
                S_TMRA: vec_of = `VIR_VEC_TMR_A;
                S_TMRB: vec_of = `VIR_VEC_TMR_B;
                S_TMRC: vec_of = `VIR_VEC_TMR_C;
                S_SER: vec_of = `VIR_VEC_SER;
                S_ADC: vec_of = `VIR_VEC_ADC;
                S_SERVO: vec_of = `VIR_VEC_SERVO;
                S_ILL: vec_of = `VIR_VEC_ILLEGAL;
                default: vec_of = `VIR_VEC_BASE;
            endcase
        end
    endfunction

    always @* begin
        events = 10'h000;
        events[S_EXTA] = ext_a_s & ~ext_a_d_reg;
        events[S_EXTB] = ext_b_s & ~ext_b_d_reg;
        events[S_WDT] = i_wdt_evt;
        events[S_TMRA] = i_tmr_a_evt;
        events[S_TMRB] = i_tmr_b_evt;
        events[S_TMRC] = i_tmr_c_evt;
        events[S_SER] = i_ser_evt;
        events[S_ADC] = i_adc_evt;
        events[S_SERVO] = i_servo_evt;
        events[S_ILL] = i_illegal_op;
    end

    // Unmaskable sources win over all; scan rises in vector order
    always @* begin
        found = 1'b0;
        win = S_EXTA;
        win_prio = `VIR_PRIO_NONE;
        cand_prio = `VIR_PRIO_NONE;
        unmasked = 1'b0;
        if (o_pending[S_ILL]) begin
            found = 1'b1;
            win = S_ILL;
        end
        if (o_pending[S_WDT]) begin
            found = 1'b1;
            win = S_WDT;
        end
        for (k = 0; k < `VIR_NSRC; k = k + 1) begin
            cand_prio = prio_of(k[3:0]);
            unmasked = o_pending[k] && (cand_prio != `VIR_PRIO_NONE) &&
                (cand_prio > i_threshold) && o_irq_enable;
            // strict compare keeps lower vector on ties
            if (!found && unmasked && (cand_prio > win_prio)) begin
                win = k[3:0];
                win_prio = cand_prio;
            end
        end
        if (!found && (win_prio != `VIR_PRIO_NONE))
            found = 1'b1;
        win_vec = vec_of(win);
    end

    // Set wins over the acknowledge clear
    always @* begin
        take = 10'h000;
        if (st_reg == ST_REQ && i_ack)
            take[sel_reg] = 1'b1;
        pend_next = (o_pending & ~take) | events;
    end

    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_core_rst <= 1'b1;
            o_start_addr <= `VIR_START_ADDR;
        end else begin
            o_core_rst <= rst_pin_s;
            o_start_addr <= `VIR_START_ADDR;
        end
    end

    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ext_a_d_reg <= 1'b0;
            ext_b_d_reg <= 1'b0;
            o_pending <= `VIR_PEND_RST;
            o_irq_enable <= 1'b0;
            st_reg <= ST_IDLE;
            sel_reg <= S_EXTA;
            o_irq_req <= 1'b0;
            o_irq_vec <= `VIR_VEC_BASE;
            o_irq_prio <= `VIR_PRIO_NONE;
            o_port_out <= `VIR_PORT_RST;
            o_port_oe <= `VIR_DIR_RST;
            o_ctl <= `VIR_CTL_RST;
        end else if (rst_pin_s) begin
            ext_a_d_reg <= ext_a_s;
            ext_b_d_reg <= ext_b_s;
            o_pending <= `VIR_PEND_RST;
            o_irq_enable <= 1'b0;
            st_reg <= ST_IDLE;
            sel_reg <= S_EXTA;
            o_irq_req <= 1'b0;
            o_irq_vec <= `VIR_VEC_BASE;
            o_irq_prio <= `VIR_PRIO_NONE;
            o_port_out <= `VIR_PORT_RST;
            o_port_oe <= `VIR_DIR_RST;
            o_ctl <= `VIR_CTL_RST;
        end else begin
            ext_a_d_reg <= ext_a_s;
            ext_b_d_reg <= ext_b_s;
            o_pending <= pend_next;
            if (i_irq_disable)
                o_irq_enable <= 1'b0;
            else if (i_irq_enable_set)
                o_irq_enable <= 1'b1;
            if (i_port_out_we)
                o_port_out <= i_port_out_wr;
            if (i_port_dir_we)
                o_port_oe <= i_port_dir_wr;
            if (i_ctl_we)
                o_ctl <= i_ctl_wr;
            case (st_reg)
                ST_IDLE: begin
                    if (found) begin
                        st_reg <= ST_REQ;
                        sel_reg <= win;
                        o_irq_req <= 1'b1;
                        o_irq_vec <= win_vec;
                        o_irq_prio <= win_prio;
                    end
                end
                ST_REQ: begin
                    // Offer held stable until the core takes it
                    if (i_ack) begin
                        st_reg <= ST_IDLE;
                        o_irq_req <= 1'b0;
                    end
                end
                default: begin
                    st_reg <= ST_IDLE;
                    o_irq_req <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [rtl/vir_map.vh]
`ifndef VIR_MAP_VH
`define VIR_MAP_VH
`define VIR_NSRC 10
`define VIR_SRC_W 4
`define VIR_PRIO_W 3
`define VIR_ADDR_W 16
`define VIR_PRIO_NONE 3'h0
`define VIR_PRIO_EXT_A 3'h7
`define VIR_PRIO_EXT_B 3'h4
`define VIR_PRIO_TMR_A 3'h6
`define VIR_PRIO_TMR_B 3'h3
`define VIR_PRIO_TMR_C 3'h3
`define VIR_PRIO_SER 3'h1
`define VIR_PRIO_ADC 3'h2
`define VIR_PRIO_SERVO 3'h5
`define VIR_VEC_EXT_A 16'h1000
`define VIR_VEC_WDT 16'h1006
`define VIR_VEC_TMR_A 16'h1008
`define VIR_VEC_TMR_B 16'h100a
`define VIR_VEC_TMR_C 16'h100c
`define VIR_VEC_SER 16'h100e
`define VIR_VEC_ADC 16'h1012
`define VIR_VEC_SERVO 16'h1014
`define VIR_VEC_ILLEGAL 16'h101e
`define VIR_VEC_BASE 16'h1000
`define VIR_VEC_TOP 16'h101f
`define VIR_START_ADDR 16'h1020
`define VIR_PORT_W 8
`define VIR_PORT_RST 8'h00
`define VIR_DIR_RST 8'h00
`define VIR_CTL_W 8
`define VIR_CTL_RST 8'h00
`define VIR_PEND_RST 10'h000
`define VIR_ST_IDLE 2'h0
`define VIR_ST_REQ 2'h1
`endif

// [rtl/vir_sync2.v]
`timescale 1ns/1ps
`default_nettype none
module vir_sync2 (
    input wire i_clk, // System clock
    input wire i_nrst, // Async reset, active low
    input wire i_d, // Asynchronous level
    output wire o_q // Synchronised level
);
    reg meta_reg;
    reg sync_reg;
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= i_d;
            sync_reg <= meta_reg;
        end
    end
    assign o_q = sync_reg;
endmodule
`default_nettype wire

// [test/tb_vir_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_vir_ctrl;
    localparam [15:0] EXT_B = 16'h1002;
    reg clk = 1'b0, nrst = 1'b0, pin = 1'b0, ea = 1'b0, eb = 1'b0;
    reg [9:0] pb = 10'h000;
    reg [2:0] thr = 3'h0, we = 3'h0;
    reg [3:0] wt = 4'h0;
    reg [7:0] wd = 8'h00;
    wire ack, req, ena, crst;
    wire [15:0] vec, sa;
    wire [2:0] prio;
    wire [9:0] pend;
    wire [7:0] pout, poe, ctl;
    integer failures = 0, check_count = 0, cyc = 0, i, n;
    // Event, threshold one below its level (7 for the unmaskable rows), vector, level
    reg [29:0] rows [0:7] = '{
        {8'h01, 3'h7, 16'h1006, 3'h0}, {8'h02, 3'h5, 16'h1008, 3'h6},
        {8'h04, 3'h2, 16'h100a, 3'h3}, {8'h08, 3'h2, 16'h100c, 3'h3},
        {8'h10, 3'h0, 16'h100e, 3'h1}, {8'h20, 3'h1, 16'h1012, 3'h2},
        {8'h40, 3'h4, 16'h1014, 3'h5}, {8'h80, 3'h7, 16'h101e, 3'h0}};
    always #12.5 clk = ~clk;
    vir_ctrl #(.EXT_B_VEC(EXT_B)) i_dut (.i_clk(clk), .i_nrst(nrst),
        .i_reset_pin(pin), .i_ext_irq_line_a(ea), .i_ext_irq_line_b(eb),
        .i_wdt_evt(pb[0]), .i_tmr_a_evt(pb[1]), .i_tmr_b_evt(pb[2]),
        .i_tmr_c_evt(pb[3]), .i_ser_evt(pb[4]), .i_adc_evt(pb[5]),
        .i_servo_evt(pb[6]), .i_illegal_op(pb[7]), .i_threshold(thr),
        .i_irq_enable_set(pb[8]), .i_irq_disable(pb[9]), .i_ack(ack),
        .i_port_out_wr(wd), .i_port_out_we(we[0]), .i_port_dir_wr(wd),
        .i_port_dir_we(we[1]), .i_ctl_wr(wd), .i_ctl_we(we[2]),
        .o_irq_req(req), .o_irq_vec(vec), .o_irq_prio(prio),
        .o_pending(pend), .o_irq_enable(ena), .o_core_rst(crst),
        .o_start_addr(sa), .o_port_out(pout), .o_port_oe(poe), .o_ctl(ctl));
    vir_core_model i_core (.i_clk(clk), .i_nrst(nrst), .i_req(req),
        .i_held(crst), .i_wait(wt), .o_ack(ack));
    task check(input [79:0] name, input [15:0] seen, input [15:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("wrong value %0s expected %h seen %h", name, exp, seen);
        end
    endtask
    task finish_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            failures = failures + 1;
            finish_test;
        end
    end
    task pulse(input [9:0] e);
        @(posedge clk) pb <= e;
        @(posedge clk) pb <= 10'h000;
    endtask
    // Bounded waits so a lost request cannot hang the run
    task offer(input [15:0] v, input [2:0] p);
        i = 0;
        while (req !== 1'b1 && i < 20) begin
            @(posedge clk) #1;
            i = i + 1;
        end
        check("request", req, 1);
        check("vector", vec, v);
        check("priority", prio, p);
        while (req === 1'b1 && i < 40) begin
            @(posedge clk) #1;
            i = i + 1;
        end
    endtask
    task quiet(input integer c);
        i = 0;
        repeat (c) begin
            @(posedge clk) #1;
            if (req !== 1'b0) i = 1;
        end
        check("quiet", i, 0);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        #1 check("enable", ena, 0);
        check("ports", {pout, poe}, 0);
        check("control", ctl, 0);
        check("start", sa, 16'h1020);
        check("core reset", crst, 0);
        $display("reset defaults done");
        pulse(10'h100);
        for (n = 0; n < 8; n = n + 1) begin
            @(posedge clk);
            thr <= rows[n][21:19];
            wt <= n[3:0];
            pulse({2'b00, rows[n][29:22]});
            offer(rows[n][18:3], rows[n][2:0]);
            $display("row %0d done", n);
        end
        @(posedge clk);
        thr <= 3'h6;
        pulse(10'h002);
        quiet(8);
        check("pending", pend[3], 1);
        @(posedge clk);
        thr <= 3'h5;
        offer(16'h1008, 3'h6);
        $display("threshold done");
        pulse(10'h200);
        thr <= 3'h0;
        pulse(10'h040);
        quiet(8);
        check("enable", ena, 0);
        pulse(10'h100);
        offer(16'h1014, 3'h5);
        $display("disable done");
        pulse(10'h300);
        #1 check("enable", ena, 0);
        pulse(10'h100);
        $display("disable and enable done");
        pulse(10'h06c);
        offer(16'h1014, 3'h5);
        offer(16'h100a, 3'h3);
        offer(16'h100c, 3'h3);
        offer(16'h1012, 3'h2);
        $display("order done");
        pulse(10'h0c1);
        offer(16'h1006, 3'h0);
        offer(16'h101e, 3'h0);
        offer(16'h1014, 3'h5);
        $display("unmaskable order done");
        @(posedge clk);
        ea <= 1'b1;
        eb <= 1'b1;
        offer(16'h1000, 3'h7);
        offer(EXT_B, 3'h4);
        $display("external lines done");
        @(posedge clk);
        ea <= 1'b0;
        eb <= 1'b0;
        wd <= 8'ha5;
        we <= 3'h7;
        @(posedge clk) we <= 3'h0;
        @(posedge clk) #1 check("ports", {pout, poe}, 16'ha5a5);
        check("control", ctl, 8'ha5);
        @(posedge clk) pin <= 1'b1;
        repeat (8) @(posedge clk);
        #1 check("core reset", crst, 1);
        check("enable", ena, 0);
        check("ports", {pout, poe}, 0);
        check("control", ctl, 0);
        @(posedge clk) pin <= 1'b0;
        repeat (8) @(posedge clk);
        #1 check("core reset", crst, 0);
        $display("pin reset done");
        finish_test;
    end
endmodule
`default_nettype wire

// [test/vir_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module vir_core_model (
    input wire i_clk, // Core clock
    input wire i_nrst, // Async reset, active low
    input wire i_req, // Request offered to core
    input wire i_held, // Core held in reset
    input wire [3:0] i_wait, // Stall before taking
    output reg o_ack // Takes the offered vector
);
    reg [3:0] wait_reg;
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wait_reg <= 4'h0;
            o_ack <= 1'b0;
        end else if (i_held || o_ack || !i_req) begin
            wait_reg <= 4'h0;
            o_ack <= 1'b0;
        end else if (wait_reg == i_wait) begin
            o_ack <= 1'b1;
        end else begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule
`default_nettype wire

// [test/vir_ctrl_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module vir_ctrl_chk #(
    parameter [15:0] EXT_B_VEC = 16'h1002
) (
    input wire logic i_clk, // System clock
    input wire logic i_nrst, // Async reset, active low
    input wire logic i_ack, // Core takes the offer
    input wire logic i_tmr_c_evt, // Timer c event pulse
    input wire logic [2:0] i_threshold, // Priority threshold field
    input wire logic o_irq_req, // Request offered to core
    input wire logic o_irq_enable, // Global enable flag
    input wire logic o_core_rst, // Core held in reset
    input wire logic [15:0] o_irq_vec, // Offered vector
    input wire logic [15:0] o_start_addr, // Fetch address after reset
    input wire logic [2:0] o_irq_prio, // Offered priority
    input wire logic [9:0] o_pending, // Pending flags
    input wire logic [7:0] o_port_out, // Output latch
    input wire logic [7:0] o_port_oe, // Pin drive enables
    input wire logic [7:0] o_ctl // Peripheral control
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // Unmaskable vectors fall to the default level 0
    function automatic [2:0] vprio(input [15:0] v);
        case (v)
            16'h1000: vprio = 3'h7;
            EXT_B_VEC: vprio = 3'h4;
            16'h1008: vprio = 3'h6;
            16'h100a, 16'h100c: vprio = 3'h3;
            16'h100e: vprio = 3'h1;
            16'h1012: vprio = 3'h2;
            16'h1014: vprio = 3'h5;
            default: vprio = 3'h0;
        endcase
    endfunction
    sequence s_taken;
        o_irq_req && i_ack;
    endsequence
    a_start_fixed: assert property (o_start_addr == 16'h1020)
        else $error("start address moved");
    a_offer_stands: assert property (o_irq_req && !i_ack |=>
        o_irq_req && $stable(o_irq_vec) && $stable(o_irq_prio))
        else $error("offer changed before ack");
    a_ack_drops: assert property (s_taken |=> !o_irq_req)
        else $error("request stayed after ack");
    a_mask_pass: assert property ($rose(o_irq_req) &&
        o_irq_prio != 3'h0 |-> $past(o_irq_enable) &&
        o_irq_prio > $past(i_threshold))
        else $error("masked request offered");
    a_vec_prio: assert property (
        o_irq_req |-> o_irq_prio == vprio(o_irq_vec))
        else $error("priority does not fit vector");
    a_vec_range: assert property (o_irq_req |->
        o_irq_vec[15:5] == 11'h080 && !o_irq_vec[0])
        else $error("vector outside table");
    a_pend_set: assert property (i_tmr_c_evt |=> o_pending[5])
        else $error("event not pending");
    a_reset_clean: assert property ($fell(o_core_rst) |->
        !o_irq_enable && {o_port_out, o_port_oe, o_ctl} == 24'h000000)
        else $error("state not cleared by reset");
    a_tie_lower: assert property ($rose(o_irq_req) &&
        o_irq_vec == 16'h100c |-> !$past(o_pending[4]))
        else $error("tie went to higher vector");
endmodule
bind vir_ctrl vir_ctrl_chk #(.EXT_B_VEC(EXT_B_VEC)) i_chk (.*);
`default_nettype wire
